// [cpu_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// cpu core stand-in: accepts the presented request on a go pulse
// ****************************************************************
module cpu_model (
  input  wire logic       clk_in,         // system clock
  input  wire logic       irq_req_in,     // request from the unit
  input  wire logic [5:0] irq_src_in,     // presented source
  input  wire logic       accept_done_in, // acceptance finished
  input  wire logic       go_in,          // one-cycle permit from the bench
  input  wire logic [1:0] delay_in,       // extra wait before accepting
  output logic            accept_out,     // accept pulse
  output logic      [5:0] taken_src_out,  // source at the accept edge
  output logic      [9:0] span_out,       // edges from accept to done
  output logic      [7:0] taken_cnt_out   // acceptances so far
);
  int n;

  initial
  begin
    accept_out    = 1'b0;
    taken_src_out = 6'h00;
    span_out      = 10'h000;
    taken_cnt_out = 8'h00;
    forever
    begin
      @(posedge clk_in);
      if (go_in === 1'b1 && irq_req_in === 1'b1)
      begin
        repeat (delay_in) @(posedge clk_in);
        accept_out <= 1'b1;
        @(posedge clk_in);
        accept_out    <= 1'b0;
        taken_src_out <= irq_src_in;
        n = 0;
        // next accept only once the sequence has finished
        do
        begin
          @(posedge clk_in);
          n++;
        end while (accept_done_in !== 1'b1 && n < 400);
        span_out      <= n[9:0];
        taken_cnt_out <= taken_cnt_out + 8'h01;
      end
    end
  end
endmodule

// [irq_ctrl.sv]
`timescale 1ns/1ps
module irq_ctrl (
  input  wire logic        clk_in,          // system clock, 100 MHz
  input  wire logic        sys_rst_in,      // async reset, active high
  input  wire logic [38:2] src_req_in,      // request lines, bit n = source n
  input  wire logic        swi_req_in,      // software interrupt level from cpu
  input  wire logic        accept_in,       // cpu accepts the presented request
  input  wire logic        ret_in,          // return instruction pulse
  input  wire logic        ret_imf_in,      // master enable restored by return
  input  wire logic        wb_cyc_in,       // wishbone cycle
  input  wire logic        wb_stb_in,       // wishbone strobe
  input  wire logic        wb_we_in,        // wishbone write enable
  input  wire logic [7:0]  wb_adr_in,       // wishbone byte address
  input  wire logic [3:0]  wb_sel_in,       // wishbone byte selects
  input  wire logic [31:0] wb_dat_in,       // wishbone write data
  output logic      [31:0] wb_dat_out,      // wishbone read data
  output logic             wb_ack_out,      // wishbone acknowledge
  output logic             irq_req_out,     // request to cpu
  output logic      [19:0] irq_vec_out,     // vector of best request
  output logic      [5:0]  irq_src_out,     // source number of best request
  output logic             accept_done_out, // acceptance sequence finished
  output logic             wdt_reset_out    // watchdog routed to reset
);
  import irq_pkg::*;

  localparam int ACC_LAT = ACCEPT_CLKS + 1;

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic [19:0] vec_of(input logic [5:0] n);
    logic [19:0] v;
    v = VEC_SWI;
    if (n == SRC_WDT)
      v = VEC_WDT;
    else if (n >= SRC_HI)
      v = VEC_HI - {12'h000, 6'(n - SRC_HI), 2'b00};
    else if (n >= SRC_EXT0)
      v = VEC_LO - {12'h000, 6'(n - SRC_EXT0), 2'b00};
    return v;
  endfunction

  function automatic logic [5:0] bank_base(input logic [5:0] idx, input logic lat);
    logic [5:0] b;
    b = 6'h3f;
    case (idx)
      IDX_LAT_L: b = lat ? 6'h00 : 6'h3f;
      IDX_LAT_H: b = lat ? 6'h08 : 6'h3f;
      IDX_LAT_E: b = lat ? 6'h10 : 6'h3f;
      IDX_LAT_D: b = lat ? 6'h18 : 6'h3f;
      IDX_LAT_C: b = lat ? 6'h20 : 6'h3f;
      IDX_EN_L:  b = lat ? 6'h3f : 6'h00;
      IDX_EN_H:  b = lat ? 6'h3f : 6'h08;
      IDX_EN_E:  b = lat ? 6'h3f : 6'h10;
      IDX_EN_D:  b = lat ? 6'h3f : 6'h18;
      IDX_EN_C:  b = lat ? 6'h3f : 6'h20;
      default:   b = 6'h3f;
    endcase
    return b;
  endfunction

  // ****************************************************************
  // signals
  // ****************************************************************
  logic [38:0]  lat_q;
  logic [38:0]  lat_d;
  logic [38:0]  ef_q;
  logic         imf_q;
  logic [7:0]   ctrl_q;
  logic         ack_q;
  logic [31:0]  rdat_q;
  logic         req_q;
  logic [19:0]  vec_q;
  logic [5:0]   src_q;
  logic         done_q;
  logic         wdrst_q;
  acc_state_t   st_q;
  logic [8:0]   cnt_q;
  logic [38:2]  rise;
  logic [38:0]  set_vec;
  logic [38:0]  clr_sw;
  logic [38:0]  clr_acc;
  logic [38:0]  elig;
  logic         best_hit;
  logic [5:0]   best_idx;
  logic         acc_fire;
  logic         bus_go;
  logic         bus_wr;
  logic [5:0]   idx;
  logic [5:0]   lbase;
  logic [5:0]   ebase;
  logic [38:0]  bank_bits;
  logic [38:0]  en_bits;
  logic [38:0]  wr_bits;
  logic [39:0]  ef_view;
  logic [39:0]  lat_view;

  // ****************************************************************
  // request capture
  // ****************************************************************
  req_sync #(.W(37)) u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .req_in     (src_req_in),
    .rise_out   (rise)
  );

  always_comb
  begin
    set_vec = {rise, 2'b00} & LAT_MASK; // RULE3 RULE9
    // watchdog routed to reset leaves its latch alone
    if (ctrl_q[WDSEL_BIT])
      set_vec[2] = 1'b0;
  end

  // ****************************************************************
  // register bus decode
  // ****************************************************************
  assign bus_go    = wb_cyc_in & wb_stb_in & ~ack_q;
  assign bus_wr    = bus_go & wb_we_in & wb_sel_in[0];
  assign idx       = wb_adr_in[7:ADR_LSB];
  assign lbase     = bank_base(idx, 1'b1);
  assign ebase     = bank_base(idx, 1'b0);
  assign bank_bits = 39'(40'h00_0000_00ff << lbase);
  assign en_bits   = 39'(40'h00_0000_00ff << ebase);
  assign wr_bits   = 39'({32'h0000_0000, wb_dat_in[7:0]} << lbase);
  assign ef_view   = {1'b0, ef_q[38:1], imf_q};
  assign lat_view  = {1'b0, lat_q};

  // write zero clears, write one leaves; never sets
  always_comb
  begin
    clr_sw = '0;
    if (bus_wr && lbase != 6'h3f)
      clr_sw = bank_bits & ~wr_bits & LAT_MASK; // RULE12 RULE13 RULE21
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q  <= bus_go;
      rdat_q <= 32'h0000_0000;
      if (bus_go && !wb_we_in)
      begin
        if (lbase != 6'h3f)
          rdat_q[7:0] <= 8'(lat_view >> lbase); // RULE12
        else if (ebase != 6'h3f)
          rdat_q[7:0] <= 8'(ef_view >> ebase);
        else if (idx == IDX_CTRL)
          rdat_q[7:0] <= ctrl_q;
        else if (idx == IDX_STAT)
          rdat_q[7:0] <= {req_q, st_q == ST_ACCEPT, src_q};
      end
    end
  end

  // ****************************************************************
  // enables and control
  // ****************************************************************
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      ef_q <= '0;
    else if (bus_wr && ebase != 6'h3f)
      ef_q <= ((ef_q & ~en_bits) | (39'({32'h0000_0000, wb_dat_in[7:0]} << ebase)
              & en_bits)) & EF_MASK;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      imf_q <= 1'b0;
    else if (acc_fire)
      imf_q <= 1'b0; // RULE20
    else if (ret_in)
      imf_q <= ret_imf_in;
    else if (bus_wr && idx == IDX_EN_L)
      imf_q <= wb_dat_in[IMF_BIT];
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      ctrl_q <= CTRL_RST;
    else if (bus_wr && idx == IDX_CTRL)
      ctrl_q <= {6'h00, wb_dat_in[WDSEL_BIT], wb_dat_in[GATE_BIT]};
  end

  // ****************************************************************
  // latches
  // ****************************************************************
  always_comb
  begin
    clr_acc = '0;
    if (acc_fire)
      clr_acc[src_q] = 1'b1; // RULE10
    // a new request in the clearing cycle wins
    lat_d = ((lat_q & ~clr_sw & ~clr_acc) | set_vec) & LAT_MASK; // RULE19
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      lat_q <= '0; // RULE11
    else
      lat_q <= lat_d;
  end

  // ****************************************************************
  // priority and vector
  // ****************************************************************
  always_comb
  begin
    elig     = lat_q & ef_q & {NSRC{imf_q}}; // RULE4
    elig[3]  = elig[3] & ctrl_q[GATE_BIT]; // RULE5
    elig[2]  = lat_q[2]; // RULE2
    elig[1]  = swi_req_in; // RULE2
    best_hit = 1'b0;
    best_idx = 6'h00;
    // lowest number wins; swi and watchdog never meet in practice
    for (int i = NSRC - 1; i >= 1; i--) // RULE6 RULE7
    begin
      if (elig[i])
      begin
        best_hit = 1'b1;
        best_idx = 6'(i);
      end
    end
  end

  // new best each cycle, so a higher source can nest when master enable is back
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      req_q <= 1'b0;
      vec_q <= VEC_SWI;
      src_q <= 6'h00;
    end
    else
    begin
      req_q <= best_hit & (st_q == ST_IDLE) & ~acc_fire; // RULE1 RULE22
      vec_q <= vec_of(best_idx); // RULE8
      src_q <= best_idx;
    end
  end

  // ****************************************************************
  // acceptance sequence
  // ****************************************************************
  assign acc_fire = accept_in & req_q & (st_q == ST_IDLE);

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_q   <= ST_IDLE;
      cnt_q  <= 9'h000;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          if (acc_fire)
          begin
            st_q  <= ST_ACCEPT;
            cnt_q <= 9'(ACCEPT_CLKS - 1); // RULE19
          end
        end
        ST_ACCEPT:
        begin
          if (cnt_q == 9'h000)
          begin
            st_q   <= ST_IDLE;
            done_q <= 1'b1;
          end
          else
            cnt_q <= cnt_q - 9'h001;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      wdrst_q <= 1'b0;
    else
      wdrst_q <= rise[2] & ctrl_q[WDSEL_BIT];
  end

  assign wb_ack_out      = ack_q;
  assign wb_dat_out      = rdat_q;
  assign irq_req_out     = req_q;
  assign irq_vec_out     = vec_q;
  assign irq_src_out     = src_q;
  assign accept_done_out = done_q;
  assign wdt_reset_out   = wdrst_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_imf_cleared: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE20
    acc_fire |=> !imf_q) else $error("master enable not cleared on accept");
  chk_latch_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE10
    acc_fire && !set_vec[src_q] |=> !lat_q[$past(src_q)]) else $error("latch kept");
  chk_no_sw_set: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE12
    ((lat_q & ~$past(lat_q) & ~$past(set_vec)) == '0)) else $error("latch set w/o event");
  chk_mask_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE4
    req_q && src_q > SRC_WDT |-> $past(imf_q) && $past(ef_q[best_idx]))
    else $error("masked source requested");
  chk_ext0_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE5
    req_q && src_q == SRC_EXT0 |-> $past(ctrl_q[GATE_BIT])) else $error("ext0 gate ignored");
  chk_accept_len: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE19
    acc_fire |-> ##ACC_LAT done_q) else $error("acceptance length wrong");
  chk_wdt_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE8
    req_q && src_q == SRC_WDT |-> vec_q == VEC_WDT) else $error("watchdog vector wrong");
  chk_ack_single: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ack_q |=> !ack_q) else $error("ack held two cycles");
  chk_wdt_nmi: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE2
    $past(lat_q[2]) && $past(st_q == ST_IDLE) && !$past(acc_fire) |-> req_q)
    else $error("watchdog request not raised");

endmodule

// [irq_pkg.sv]
// Functional notes
// RULE1 - thirty-eight sources besides reset; higher priority nests inside lower service
// RULE2 - software and watchdog requests ignore the master enable; others are maskable
// RULE3 - request sets its latch; the cpu is asked only when enabled
// RULE4 - maskable source n (3..38) needs master enable and its own enable flag
// RULE5 - external interrupt 0 also needs its pin gate set
// RULE6 - fixed acceptance order, lower number wins, 38 lowest
// RULE7 - non-maskable sources are not ranked against one another; the code ranks software (1) ahead of watchdog (2)
// RULE8 - each source has its own fixed vector address
// RULE9 - no latch for software or undefined-instruction interrupt
// RULE10 - accepted source latch clears at once on acceptance
// RULE11 - reset clears every request latch
// RULE12 - software reads latches and clears bits; a write never sets one
// RULE13 - each latch bit clears alone; bits written as one stay
// RULE14 - software keeps watchdog and ext0 latches; writes one to watchdog bit
// RULE15 - software clears latches with plain writes, not read-modify-write
// RULE16 - main program drops master enable before touching enables or latches
// RULE17 - nested service finishes enable or latch edits before raising master enable
// RULE18 - software clears watchdog output select to get an interrupt, not reset
// RULE19 - acceptance lasts twelve machine cycles; pending request held until taken
// RULE20 - acceptance clears master enable until the return restores it
// RULE21 - writing zero clears a latch bit, writing one leaves it
// RULE22 - highest pending enabled source vector presented, recomputed every cycle
package irq_pkg;

  // ****************************************************************
  // sources and masks
  // ****************************************************************
  localparam int             NSRC      = 39;
  localparam logic [38:0]    LAT_MASK  = 39'h7f_ffff_fffc;
  localparam logic [38:0]    EF_MASK   = 39'h7f_ffff_fff8;
  localparam logic [5:0]     SRC_SWI   = 6'h01;
  localparam logic [5:0]     SRC_WDT   = 6'h02;
  localparam logic [5:0]     SRC_EXT0  = 6'h03;
  localparam logic [5:0]     SRC_HI    = 6'h20;

  // ****************************************************************
  // vectors
  // ****************************************************************
  localparam logic [19:0]    VEC_SWI   = 20'hf_fff8;
  localparam logic [19:0]    VEC_WDT   = 20'hf_fff4;
  localparam logic [19:0]    VEC_LO    = 20'hf_fff0;
  localparam logic [19:0]    VEC_HI    = 20'hf_ff3c;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0]     IDX_LAT_L = 6'h3c;
  localparam logic [5:0]     IDX_LAT_H = 6'h3d;
  localparam logic [5:0]     IDX_LAT_E = 6'h2e;
  localparam logic [5:0]     IDX_LAT_D = 6'h2f;
  localparam logic [5:0]     IDX_LAT_C = 6'h2b;
  localparam logic [5:0]     IDX_EN_L  = 6'h3a;
  localparam logic [5:0]     IDX_EN_H  = 6'h3b;
  localparam logic [5:0]     IDX_EN_E  = 6'h2c;
  localparam logic [5:0]     IDX_EN_D  = 6'h2d;
  localparam logic [5:0]     IDX_EN_C  = 6'h2a;
  localparam logic [5:0]     IDX_CTRL  = 6'h30;
  localparam logic [5:0]     IDX_STAT  = 6'h31;
  localparam int             ADR_LSB   = 2;
  localparam int             IMF_BIT   = 0;
  localparam int             GATE_BIT  = 0;
  localparam int             WDSEL_BIT = 1;
  localparam logic [7:0]     CTRL_RST  = 8'h02;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int             CLK_PERIOD_NS = 10;
  localparam int             ACCEPT_NS     = 2400;
  localparam int             ACCEPT_CLKS   = (ACCEPT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b01,
    ST_ACCEPT = 2'b10
  } acc_state_t;

endpackage

// [prioritized_interrupt_latch_unit_tb.sv]
`timescale 1ns/1ps
module prioritized_interrupt_latch_unit_tb;
  import irq_pkg::*;
  logic        clk_in, sys_rst_in, swi_req, accept, ret, ret_imf, cyc, stb, we;
  logic        go, ack, irq_req, done, wdt_rst;
  logic [38:2] src_req;
  logic [7:0]  adr, tcnt;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rng;
  logic [19:0] vec;
  logic [5:0]  src, taken_src;
  logic [1:0]  dly;
  logic [9:0]  span;
  bit   [39:0] lat, en;
  bit          master_irq_enable, gate;
  int          bad_count, checks, wdt_pulses;
  logic [7:0]  lat_adr [5] = '{8'hf0, 8'hf4, 8'hb8, 8'hbc, 8'hac};
  logic [7:0]  en_adr [5] = '{8'he8, 8'hec, 8'hb0, 8'hb4, 8'ha8};

  irq_ctrl dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .src_req_in(src_req),
    .swi_req_in(swi_req), .accept_in(accept), .ret_in(ret), .ret_imf_in(ret_imf),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .irq_req_out(irq_req),
    .irq_vec_out(vec), .irq_src_out(src), .accept_done_out(done), .wdt_reset_out(wdt_rst));

  cpu_model partner (.clk_in(clk_in), .irq_req_in(irq_req), .irq_src_in(src),
    .accept_done_in(done), .go_in(go), .delay_in(dly), .accept_out(accept),
    .taken_src_out(taken_src), .span_out(span), .taken_cnt_out(tcnt));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // counts reset-request pulses routed from the watchdog source
  always @(posedge clk_in)
  begin
    if (wdt_rst === 1'b1)
      wdt_pulses++;
  end

  // ****************************************************************
  // checking and bus helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [19:0] vexp(input int n);
    if (n == 1) return 20'hf_fff8;
    if (n == 2) return 20'hf_fff4;
    if (n < 32) return 20'hf_fff0 - 20'(4 * (n - 3));
    return 20'hf_ff3c - 20'(4 * (n - 32));
  endfunction

  function automatic int best();
    for (int n = 1; n < 39; n++)
    begin
      if ((n == 1 && swi_req === 1'b1) || (n == 2 && lat[2]) ||
          (n == 3 && lat[3] && master_irq_enable && en[3] && gate) || (n > 3 && lat[n] && master_irq_enable && en[n]))
        return n;
    end
    return 0;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'h1;
    wdat <= {24'h00_0000, d};
    do
    begin
      @(posedge clk_in);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    chk("bus_hi", 32'h0, {8'h00, rdat[31:8]});
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(what, {24'h0, e}, {24'h0, q});
  endtask

  task automatic rd_all();
    for (int k = 0; k < 5; k++)
    begin
      rd("latch", lat_adr[k], lat[k*8+:8]);
      rd("enable", en_adr[k], en[k*8+:8] | {7'h00, master_irq_enable && k == 0});
    end
  endtask

  task automatic wr_en();
    for (int k = 0; k < 5; k++)
      wr(en_adr[k], en[k*8+:8] | {7'h00, master_irq_enable && k == 0});
  endtask

  task automatic raise(input bit [39:0] m);
    src_req <= m[38:2];
    repeat (2) @(posedge clk_in);
    src_req <= '0;
    repeat (8) @(posedge clk_in);
    lat = lat | (m & 40'h7f_ffff_fffc);
  endtask

  task automatic see_irq();
    int b;
    repeat (3) @(posedge clk_in);
    b = best();
    chk("irq_req", {31'h0, b != 0}, {31'h0, irq_req});
    if (b != 0)
    begin
      chk("irq_src", 32'(b), {26'h0, src});
      chk("irq_vec", {12'h0, vexp(b)}, {12'h0, vec});
    end
  endtask

  task automatic run_accepts();
    int         b;
    int         n;
    logic [7:0] old;
    repeat (40)
    begin
      see_irq();
      b = best();
      if (b == 0)
        break;
      old = tcnt;
      rng = lfsr(rng);
      dly <= rng[1:0];
      go  <= 1'b1;
      @(posedge clk_in);
      go <= 1'b0;
      n = 0;
      while (tcnt === old && n < 600)
      begin
        @(posedge clk_in);
        n++;
      end
      chk("taken_src", 32'(b), {26'h0, taken_src});
      chk("accept_span", 32'(ACCEPT_CLKS + 1), {22'h0, span});
      lat[b] = 1'b0;
      master_irq_enable = 1'b0;
      rd("latch_taken", lat_adr[b/8], lat[(b/8)*8+:8]);
      rd("master_en", 8'he8, en[7:0]);
      ret_imf <= 1'b1;
      ret     <= 1'b1;
      @(posedge clk_in);
      ret <= 1'b0;
      master_irq_enable = 1'b1;
    end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    sys_rst_in = 1'b1;
    swi_req = 1'b0;
    ret = 1'b0;
    ret_imf = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    go = 1'b0;
    dly = 2'b00;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    src_req = '0;
    rng = 32'h64ac;
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    chk("vec_reset", 32'h000f_fff8, {12'h0, vec});
    rd_all();
    rd("control", 8'hc0, CTRL_RST);
    rd("unmapped", 8'h00, 8'h00);
    raise(40'h04);
    // output select still 1 after reset: a reset pulse, no latch
    lat[2] = 1'b0;
    chk("wdt_reset", 32'h1, 32'(wdt_pulses));
    rd("wdt_no_latch", 8'hf0, lat[7:0]);
    wr(8'hc0, 8'h00);
    rng = lfsr(rng);
    en = {rng[7:0], lfsr(rng)} & 40'h7f_ffff_fff8 | 40'h08;
    wr_en();
    rng = lfsr(rng);
    raise({rng[7:0], lfsr(rng)} | 40'h0c);
    rd_all();
    see_irq();
    for (int k = 0; k < 5; k++)
    begin
      rng = lfsr(rng);
      wr(lat_adr[k], rng[7:0] | (k == 0 ? 8'h0c : 8'h00));
      lat[k*8+:8] = lat[k*8+:8] & (rng[7:0] | (k == 0 ? 8'h0c : 8'h00));
    end
    rd_all();
    rng = lfsr(rng);
    raise({rng[15:8], rng} | 40'h08);
    master_irq_enable = 1'b1;
    wr_en();
    run_accepts();
    rd("ext0_held", 8'hf0, lat[7:0]);
    gate = 1'b1;
    wr(8'hc0, 8'h01);
    run_accepts();
    master_irq_enable = 1'b0;
    wr_en();
    swi_req <= 1'b1;
    see_irq();
    rd("status", 8'hc4, {2'b10, SRC_SWI});
    swi_req <= 1'b0;
    rd("swi_no_latch", 8'hf0, lat[7:0]);
    summarize();
  end

  initial
  begin
    repeat (60000) @(posedge clk_in);
    bad_count++;
    summarize();
  end
endmodule

// [req_sync.sv]
`timescale 1ns/1ps
module req_sync #(
  parameter int W = 37
) (
  input  wire logic         clk_in,     // system clock
  input  wire logic         sys_rst_in, // async reset, active high
  input  wire logic [W-1:0] req_in,     // raw request lines
  output logic      [W-1:0] rise_out    // one-cycle pulse per filtered rise
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= req_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      lvl_q    <= '0;
      rise_out <= '0;
    end
    else
    begin
      lvl_q    <= (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
      rise_out <= s2_q & s3_q & ~lvl_q;
    end
  end

endmodule
